// >>> hw/spi_clock_stop_port.sv
// Behaviour
// - Source select 1: input clock is pclk/2
// - Bit period is input clock times divider+1 (divider 0 gives two input clocks here)
// - High phase length follows divider parity
// - Low phase length follows divider parity
// - Slave role forces source 1, divider 1
// - Master drives sync inverted as active-low enable
// - Slave inverts both incoming enables
// - Master drives clock and sync, receives none
// - Slave drives no clock or sync pin
// - Enable low before first rising clock edge
// - Enable low one period before first rise
// - Enable held one low phase after last fall
// - Serial output changes on falling edges
// - First bit one high phase after enable
// - Serial input sampled on rising edges
// - Output released at final falling edge
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module spi_word_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input  logic             pclk,
	input  logic             presetn,
	input  logic             clk_en,
	input  logic             in_valid,
	output logic             in_ready,
	input  logic [WIDTH-1:0] in_data,
	output logic             out_valid,
	input  logic             out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	// Extra pointer bit separates full from empty
	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage needs no reset, pointers define contents
	always_ff @(posedge pclk)
	begin
		if (clk_en && push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	// Pointers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (clk_en)
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // spi_word_fifo

module spi_clock_stop_port
	import spi_cs_pkg::*;
(
	input  logic        pclk,
	input  logic        presetn,
	input  logic        clk_en,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  logic        srg_ext_clock,
	input  logic        tx_bit_clock_pin,
	output logic        tx_bit_clock,
	output logic        tx_bit_clock_oe,
	input  logic        tx_frame_sync_pin,
	output logic        tx_frame_sync,
	output logic        tx_frame_sync_oe,
	input  logic        rx_frame_sync,
	input  logic        serial_in,
	output logic        serial_out,
	output logic        serial_out_oe
);
	ctrl_t                  ctrl;
	dir_t                   dir;
	status_t                status;
	phase_t                 state;
	logic [PIN_COUNT-1:0]   sync_s1;
	logic [PIN_COUNT-1:0]   sync_s2;
	logic [PIN_COUNT-1:0]   sync_s3;
	logic                   half_q;
	logic                   tick;
	logic                   eff_src;
	logic [7:0]             eff_div;
	logic [8:0]             h_len;
	logic [8:0]             l_len;
	logic [8:0]             t_len;
	logic [8:0]             phase_cnt;
	logic [8:0]             next_cnt;
	logic [3:0]             bits;
	logic [WORD_BITS-1:0]   tx_shift;
	logic [WORD_BITS-1:0]   rx_shift;
	logic [WORD_BITS-1:0]   rx_word;
	logic                   rx_done;
	logic                   rx_valid;
	logic                   master;
	logic                   mode_ok;
	logic                   run_master;
	logic                   run_slave;
	logic                   tx_act;
	logic                   tx_act_d;
	logic                   rx_act;
	logic                   clk_rise;
	logic                   clk_fall;
	logic                   din;
	logic                   slave_start;
	logic                   take_word;
	logic                   fifo_in_valid;
	logic                   fifo_in_ready;
	logic                   fifo_out_valid;
	logic [WORD_BITS-1:0]   fifo_out_data;
	logic                   access;
	logic                   done;
	logic                   tx_wr;
	logic                   unmapped;
	logic [31:0]            rd_word;
	logic [8:0]             per_cnt;
	logic [1:0]             clk_hist;
	logic                   m_sample;

	// Configuration decode
	assign master     = ctrl.master_role;
	assign mode_ok    = ctrl.clock_stop_select == CSTOP_HALF_DELAY && !ctrl.tx_clock_polarity;
	assign run_master = ctrl.port_enable & mode_ok & master;
	assign run_slave  = ctrl.port_enable & mode_ok & ~master;

	// Slave role ignores software generator settings
	assign eff_src = master ? ctrl.srg_clock_source_select : SLAVE_SRG_SOURCE;
	assign eff_div = master ? ctrl.srg_divider_value : SLAVE_SRG_DIVIDER;
	assign h_len   = high_len(eff_div);
	assign l_len   = low_len(eff_div);
	assign t_len   = {1'b0, eff_div} + 9'h001;
	assign next_cnt = phase_cnt + 9'h001;

	// Pin synchronisers; third stage only feeds edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_s1 <= '0;
			sync_s2 <= '0;
			sync_s3 <= '0;
		end
		else if (clk_en)
		begin
			sync_s1 <= {serial_in, rx_frame_sync, tx_frame_sync_pin, tx_bit_clock_pin, srg_ext_clock};
			sync_s2 <= sync_s1;
			sync_s3 <= sync_s2;
		end
	end

	// Incoming enables are active low when polarity set
	assign tx_act   = sync_level(sync_s2[PIN_FSX], ctrl.tx_sync_polarity);
	assign rx_act   = sync_level(sync_s2[PIN_FSR], ctrl.rx_sync_polarity);
	assign clk_rise = sync_s2[PIN_CLK] & ~sync_s3[PIN_CLK];
	assign clk_fall = ~sync_s2[PIN_CLK] & sync_s3[PIN_CLK];
	assign din      = sync_s2[PIN_DIN];

	// Generator input clock: pclk/2 or external pin edges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			half_q <= 1'b0;
		else if (clk_en)
			half_q <= ~half_q;
	end
	// External clock limited to below pclk/2 by synchroniser
	assign tick = eff_src ? half_q : (sync_s2[PIN_EXT] & ~sync_s3[PIN_EXT]);

	// Enable edge memory for slave frame start; starts set so reset gives no false start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_act_d <= 1'b1;
		else if (clk_en)
			tx_act_d <= tx_act;
	end

	// Word taken from the buffer at frame start
	assign slave_start = run_slave & tx_act & ~tx_act_d;
	assign take_word   = fifo_out_valid & ((run_master & state == ST_IDLE) | slave_start);

	// Pin directions follow the role
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dir <= DIR_SLAVE;
		else if (clk_en)
			dir <= master ? DIR_MASTER : DIR_SLAVE;
	end
	assign tx_bit_clock_oe  = dir.tx_clock_direction;
	assign tx_frame_sync_oe = dir.tx_sync_direction;

	// Master sample point: synchronised input lags the pin by two clocks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_hist <= 2'b00;
		else if (clk_en)
			clk_hist <= {clk_hist[0], tx_bit_clock};
	end
	assign m_sample = clk_hist[0] & ~clk_hist[1];

	// Link engine for both roles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state         <= ST_IDLE;
			phase_cnt     <= '0;
			bits          <= '0;
			tx_shift      <= '0;
			rx_shift      <= '0;
			rx_word       <= '0;
			rx_done       <= 1'b0;
			tx_bit_clock  <= 1'b0;
			tx_frame_sync <= 1'b1;
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_done <= 1'b0;
			if (run_master)
			begin
				// Pin value as it stood at the rise, not at the previous fall
				if (m_sample)
					rx_shift <= {rx_shift[6:0], din};
				case (state)
					ST_IDLE:
					begin
						tx_bit_clock  <= 1'b0;
						tx_frame_sync <= sync_level(take_word, ctrl.tx_sync_polarity);
						if (take_word)
						begin
							tx_shift  <= fifo_out_data;
							phase_cnt <= '0;
							bits      <= '0;
							state     <= ST_LEAD;
						end
					end
					ST_LEAD:
						if (tick)
						begin
							phase_cnt <= next_cnt;
							if (next_cnt == h_len)
							begin
								serial_out_oe <= 1'b1;
								serial_out    <= tx_shift[7];
							end
							// Full period of enable before first rise
							if (next_cnt == t_len)
							begin
								tx_bit_clock <= 1'b1;
								bits         <= bits + 4'h1;
								phase_cnt    <= '0;
								state        <= ST_HIGH;
							end
						end
					ST_HIGH:
						if (tick)
						begin
							phase_cnt <= next_cnt;
							if (next_cnt == h_len)
							begin
								tx_bit_clock <= 1'b0;
								phase_cnt    <= '0;
								if (bits == LAST_BIT)
								begin
									serial_out_oe <= 1'b0;
									state         <= ST_TRAIL;
								end
								else
								begin
									serial_out <= tx_shift[6];
									tx_shift   <= tx_shift << 1;
									state      <= ST_LOW;
								end
							end
						end
					ST_LOW:
						if (tick)
						begin
							phase_cnt <= next_cnt;
							if (next_cnt == l_len)
							begin
								tx_bit_clock <= 1'b1;
								bits         <= bits + 4'h1;
								phase_cnt    <= '0;
								state        <= ST_HIGH;
							end
						end
					ST_TRAIL:
						if (tick)
						begin
							phase_cnt <= next_cnt;
							// Enable outlives the last fall by a low phase
							if (next_cnt == l_len)
							begin
								tx_frame_sync <= sync_level(1'b0, ctrl.tx_sync_polarity);
								rx_word       <= rx_shift;
								rx_done       <= 1'b1;
								state         <= ST_IDLE;
							end
						end
					default:
						state <= ST_IDLE;
				endcase
			end
			else
			begin
				// Leaving master role aborts any frame
				state         <= ST_IDLE;
				tx_bit_clock  <= 1'b0;
				tx_frame_sync <= sync_level(1'b0, ctrl.tx_sync_polarity);
				if (!run_slave || !tx_act)
				begin
					serial_out_oe <= 1'b0;
					bits          <= '0;
				end
				else if (slave_start)
				begin
					// Empty buffer sends zeros rather than stalling
					tx_shift      <= fifo_out_valid ? fifo_out_data : '0;
					serial_out    <= fifo_out_valid & fifo_out_data[7];
					serial_out_oe <= 1'b1;
					bits          <= '0;
				end
				else
				begin
					if (clk_rise && rx_act)
					begin
						rx_shift <= {rx_shift[6:0], din};
						bits     <= bits + 4'h1;
						if (bits == LAST_BIT - 4'h1)
						begin
							rx_word <= {rx_shift[6:0], din};
							rx_done <= 1'b1;
						end
					end
					if (clk_fall)
					begin
						if (bits == LAST_BIT)
							serial_out_oe <= 1'b0;
						else
						begin
							serial_out <= tx_shift[6];
							tx_shift   <= tx_shift << 1;
						end
					end
				end
			end
		end
	end

	spi_word_fifo
	#(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	)
	u_tx_fifo
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (pwdata[WORD_BITS-1:0]),
		.out_valid (fifo_out_valid),
		.out_ready (take_word),
		.out_data  (fifo_out_data)
	);

	// APB handshake terms
	assign access        = psel & penable;
	assign done          = access & pready;
	assign tx_wr         = pwrite & (paddr == OFS_TXDATA);
	assign fifo_in_valid = done & tx_wr;

	assign status = '{dir: dir, fifo_empty: ~fifo_out_valid, fifo_full: ~fifo_in_ready,
		rx_valid: rx_valid, busy: (state != ST_IDLE) | serial_out_oe};

	// Read mux and address decode
	always_comb
	begin
		rd_word  = 32'h0000_0000;
		unmapped = 1'b0;
		case (paddr)
			OFS_CTRL:   rd_word = {16'h0000, ctrl};
			OFS_STATUS: rd_word = {24'h00_0000, status};
			OFS_TXDATA: rd_word = 32'h0000_0000;
			OFS_RXDATA: rd_word = {24'h00_0000, rx_word};
			default:    unmapped = 1'b1;
		endcase
	end

	// One wait state; a full buffer holds a data write off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready <= access & ~pready & (~tx_wr | fifo_in_ready);
			if (access && !pready)
			begin
				prdata  <= rd_word;
				pslverr <= unmapped;
			end
		end
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= CTRL_RESET;
		else if (clk_en && done && pwrite && paddr == OFS_CTRL)
			ctrl <= ctrl_t'(pwdata[15:0]);
	end

	// Received flag; a new word beats the read that clears it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_valid <= 1'b0;
		else if (clk_en)
		begin
			if (rx_done)
				rx_valid <= 1'b1;
			else if (done && !pwrite && paddr == OFS_RXDATA)
				rx_valid <= 1'b0;
		end
	end

	// Ticks since the last rise, read only by checks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			per_cnt <= '0;
		else if (clk_en && tick)
			per_cnt <= ((state == ST_HIGH) || (state == ST_LOW && next_cnt != l_len)) ? per_cnt + 9'h001 : '0;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_srg_half_rate: assert property (clk_en && tick && eff_src ##1 clk_en && eff_src |-> !tick)
		else $error("generator tick faster than pclk/2");
	a_bit_period: assert property (state == ST_LOW && clk_en && tick && next_cnt == l_len
		&& eff_div != 8'h00 |-> per_cnt + 9'h001 == t_len)
		else $error("bit period not divider+1 input clocks");
	a_high_width: assert property (state == ST_HIGH |-> tx_bit_clock && phase_cnt < h_len)
		else $error("high phase overran");
	a_low_width: assert property (state == ST_LOW |-> !tx_bit_clock && phase_cnt < l_len)
		else $error("low phase overran");
	a_slave_srg: assert property (!master |-> eff_src == SLAVE_SRG_SOURCE && h_len + l_len == 9'h002)
		else $error("slave generator not pclk/2");
	a_master_enable: assert property (run_master && ctrl.tx_sync_polarity
		&& state inside {ST_HIGH, ST_LOW} |-> !tx_frame_sync)
		else $error("enable not active low in frame");
	a_slave_enable_in: assert property (ctrl.rx_sync_polarity && !sync_s2[PIN_FSR] |-> rx_act)
		else $error("receive enable not inverted");
	a_dir_master: assert property ($past(master && clk_en) |-> dir == DIR_MASTER)
		else $error("master pin directions wrong");
	a_dir_slave: assert property ($past(!master && clk_en) |-> dir == DIR_SLAVE)
		else $error("slave pin directions wrong");
	a_rise_enabled: assert property ($rose(tx_bit_clock)
		|-> tx_frame_sync == sync_level(1'b1, ctrl.tx_sync_polarity))
		else $error("clock rose without enable");
	a_lead_period: assert property (state == ST_LEAD && clk_en && tick && next_cnt == t_len
		|=> tx_bit_clock && state == ST_HIGH)
		else $error("first rise not one period after enable");
	a_trail_hold: assert property (state == ST_TRAIL
		|-> !tx_bit_clock && !serial_out_oe && tx_frame_sync == sync_level(1'b1, ctrl.tx_sync_polarity))
		else $error("enable dropped before trail ended");
	a_out_on_fall: assert property (master && $changed(serial_out)
		&& $past(state) inside {ST_HIGH, ST_LOW} |-> $fell(tx_bit_clock))
		else $error("data changed off a falling edge");
	a_first_bit: assert property (state == ST_LEAD && clk_en && tick && next_cnt == h_len
		|=> serial_out_oe && !tx_bit_clock)
		else $error("first bit not presented after high phase");
	a_sample_rise: assert property (master && $changed(rx_shift)
		|-> $past(tx_bit_clock, 2) && !$past(tx_bit_clock, 3))
		else $error("input sampled off a rising edge");
	a_release_fall: assert property ($fell(serial_out_oe) && $past(run_master)
		&& $past(state) == ST_HIGH |-> $fell(tx_bit_clock) && state == ST_TRAIL)
		else $error("output released off the last fall");
	a_slave_quiet: assert property (!master && clk_en && !tx_act |=> !serial_out_oe)
		else $error("idle slave drives output");

	c_master_frame: cover property (state == ST_TRAIL ##1 state == ST_IDLE);
	c_slave_word: cover property (!master && rx_done);
	c_fifo_full: cover property (!fifo_in_ready && access && tx_wr);
	c_slave_release: cover property (!master && $fell(serial_out_oe) && tx_act);
endmodule // spi_clock_stop_port

// >>> hw/spi_cs_pkg.sv
package spi_cs_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0C;

	// Word size and buffering
	localparam int WORD_BITS  = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] LAST_BIT = 4'h8;

	// Only the half-cycle-delay clock-stop setting is served
	localparam logic [1:0] CSTOP_HALF_DELAY = 2'b11;

	// Generator settings forced in slave role
	localparam logic       SLAVE_SRG_SOURCE  = 1'b1;
	localparam logic [7:0] SLAVE_SRG_DIVIDER = 8'h01;

	// Synchroniser lanes
	localparam int PIN_EXT   = 0;
	localparam int PIN_CLK   = 1;
	localparam int PIN_FSX   = 2;
	localparam int PIN_FSR   = 3;
	localparam int PIN_DIN   = 4;
	localparam int PIN_COUNT = 5;

	typedef struct packed {
		logic [7:0] srg_divider_value;
		logic       rx_sync_polarity;
		logic       tx_sync_polarity;
		logic       srg_clock_source_select;
		logic       tx_clock_polarity;
		logic [1:0] clock_stop_select;
		logic       master_role;
		logic       port_enable;
	} ctrl_t;

	typedef struct packed {
		logic tx_clock_direction;
		logic tx_sync_direction;
		logic rx_clock_direction;
		logic rx_sync_direction;
	} dir_t;

	typedef struct packed {
		dir_t dir;
		logic fifo_empty;
		logic fifo_full;
		logic rx_valid;
		logic busy;
	} status_t;

	localparam ctrl_t CTRL_RESET = 16'h01EC;
	localparam dir_t  DIR_MASTER = 4'hC;
	localparam dir_t  DIR_SLAVE  = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LEAD  = 3'b001,
		ST_HIGH  = 3'b011,
		ST_LOW   = 3'b010,
		ST_TRAIL = 3'b110
	} phase_t;

	// High phase length in generator input clocks
	function automatic logic [8:0] high_len(input logic [7:0] div);
		logic [8:0] d;
		d = {1'b0, div};
		if (div == 8'h00)
			return 9'h001;
		else if (div[0])
			return (d + 9'h001) >> 1;
		else
			return (d >> 1) + 9'h001;
	endfunction

	// Low phase length in generator input clocks
	function automatic logic [8:0] low_len(input logic [7:0] div);
		logic [8:0] d;
		d = {1'b0, div};
		if (div == 8'h00)
			return 9'h001;
		else if (div[0])
			return (d + 9'h001) >> 1;
		else
			return d >> 1;
	endfunction

	// Pin level for an internal sync state, inverting when polarity set
	function automatic logic sync_level(input logic active, input logic pol);
		return pol ? ~active : active;
	endfunction

endpackage

// >>> verif/serial_port_spi_clock_stop_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module serial_port_spi_clock_stop_bench
	import spi_cs_pkg::*;
;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, peer_tx, peer_rx;
	logic [31:0] pwdata, prdata, rd_v;
	logic        srg_ext_clock, ck_w, en_w, so_w, si_w, err_v;
	logic        tx_bit_clock, tx_bit_clock_oe, tx_frame_sync, tx_frame_sync_oe;
	logic        serial_out, serial_out_oe, miso, miso_oe, drv_clk, drv_en_n;
	logic        p_ck, p_fs, p_oe, p_so, bit7, oe_seen;
	logic [2:0]  ec;
	int          err_count, compares, cyc, wd, nr, nf, nfr, bad_chg;
	int          t_en0, t_en1, t_oe1, t_oe0;
	int          rise_t[8], fall_t[8];

	// Pins: enabled driver wins, data lines pulled up when released
	assign ck_w = tx_bit_clock_oe ? tx_bit_clock : drv_clk;
	assign en_w = tx_frame_sync_oe ? tx_frame_sync : drv_en_n;
	assign so_w = serial_out_oe ? serial_out : 1'b1;
	assign si_w = miso_oe ? miso : 1'b1;

	spi_clock_stop_port dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .srg_ext_clock(srg_ext_clock), .tx_bit_clock_pin(ck_w),
		.tx_bit_clock(tx_bit_clock), .tx_bit_clock_oe(tx_bit_clock_oe), .tx_frame_sync_pin(en_w),
		.tx_frame_sync(tx_frame_sync), .tx_frame_sync_oe(tx_frame_sync_oe), .rx_frame_sync(en_w),
		.serial_in(si_w), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

	spi_peer_model peer (.pclk(pclk), .clk_pin(ck_w), .en_n_pin(en_w), .mosi(so_w), .tx_byte(peer_tx),
		.miso(miso), .miso_oe(miso_oe), .drv_clk(drv_clk), .drv_en_n(drv_en_n), .rx_byte(peer_rx));

	// Clock, 100 ns period
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Slow external generator clock, 8 pclk period
	always @(posedge pclk)
	begin
		ec <= ec + 3'h1;
		srg_ext_clock <= ec[2];
	end

	// Edge log of the link outputs, all in pclk cycles
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		p_ck <= tx_bit_clock;
		p_fs <= tx_frame_sync;
		p_oe <= serial_out_oe;
		p_so <= serial_out;
		if (serial_out_oe)
			oe_seen <= 1'b1;
		if (p_fs && !tx_frame_sync)
			t_en0 <= cyc;
		if (!p_fs && tx_frame_sync && tx_frame_sync_oe)
		begin
			t_en1 <= cyc;
			nfr <= nfr + 1;
		end
		if (!p_ck && tx_bit_clock && nr < 8)
		begin
			rise_t[nr] <= cyc;
			nr <= nr + 1;
		end
		if (p_ck && !tx_bit_clock && nf < 8)
		begin
			fall_t[nf] <= cyc;
			nf <= nf + 1;
		end
		if (!p_oe && serial_out_oe)
		begin
			t_oe1 <= cyc;
			bit7 <= serial_out;
		end
		if (p_oe && !serial_out_oe)
			t_oe0 <= cyc;
		// Data may only move with a falling clock
		if (tx_bit_clock_oe && p_oe && serial_out_oe && serial_out !== p_so && !(p_ck && !tx_bit_clock))
			bad_chg <= bad_chg + 1;
	end

	// Hang guard
	always @(posedge pclk)
	begin
		wd <= wd + 1;
		if (wd == 20000)
		begin
			err_count++;
			complete_run();
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic t_regs();
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK("ctrl_reset", 32'h0000_01EC, rd_v);
		apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("status_reset", 32'h0000_0008, rd_v);
		apb(1'b0, OFS_TXDATA, 32'h0);
		`CHK("txdata_read", 32'h0, rd_v);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped_err", 1'b1, err_v);
		$display("Test regs done");
	endtask

	// Master frame with measured bit-clock geometry; tk is pclk per tick
	task automatic t_master(input logic [7:0] div, input logic src, input int tk, input logic [7:0] db, pb);
		int h, l, n0;
		h = div[0] ? (div + 1) / 2 : div / 2 + 1;
		l = div[0] ? (div + 1) / 2 : div / 2;
		n0 = nfr;
		peer_tx = pb;
		apb(1'b1, OFS_CTRL, {16'h0, div, 2'b11, src, 5'h0F});
		nr = 0;
		nf = 0;
		bad_chg = 0;
		apb(1'b1, OFS_TXDATA, {24'h0, db});
		wait (nfr == n0 + 1);
		`CHK("lead", 1'b1, (t_en0 + (div + 1) * tk - rise_t[0]) inside {[0:tk - 1]});
		`CHK("first_bit", 1'b1, (t_en0 + h * tk - t_oe1) inside {[0:tk - 1]});
		`CHK("bit7", db[7], bit7);
		`CHK("high", h * tk, fall_t[0] - rise_t[0]);
		`CHK("low", l * tk, rise_t[1] - fall_t[0]);
		`CHK("period", (div + 1) * tk, rise_t[1] - rise_t[0]);
		`CHK("rises", 8, nr);
		`CHK("release", fall_t[7], t_oe0);
		`CHK("en_hold", l * tk, t_en1 - fall_t[7]);
		`CHK("en_idle", 1'b1, tx_frame_sync);
		`CHK("data_edges", 0, bad_chg);
		`CHK("peer_rx", db, peer_rx);
		`CHK("pin_dir", 2'b11, {tx_bit_clock_oe, tx_frame_sync_oe});
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("status_dir", 4'hC, rd_v[7:4]);
		apb(1'b0, OFS_RXDATA, 32'h0);
		`CHK("dut_rx", {24'h0, pb}, rd_v);
		$display("Test master div %0d src %0d done", div, src);
	endtask

	task automatic t_slave(input logic [7:0] db, pb);
		apb(1'b1, OFS_CTRL, 32'h0000_05CD);
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK("slave_ctrl", 32'h0000_05CD, rd_v);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("slave_dir", 4'h0, rd_v[7:4]);
		`CHK("slave_oe", 2'b00, {tx_bit_clock_oe, tx_frame_sync_oe});
		apb(1'b1, OFS_TXDATA, {24'h0, db});
		// Clear the flag left by the master frames
		apb(1'b0, OFS_RXDATA, 32'h0);
		oe_seen = 1'b0;
		peer_tx = pb;
		peer.run_frame(1'b0);
		`CHK("idle_float", 1'b0, oe_seen);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("idle_no_rx", 1'b0, rd_v[1]);
		peer.run_frame(1'b1);
		repeat (4) @(posedge pclk);
		`CHK("slave_tx", db, peer_rx);
		`CHK("slave_released", 1'b0, serial_out_oe);
		apb(1'b0, OFS_RXDATA, 32'h0);
		`CHK("slave_rx", {24'h0, pb}, rd_v);
		$display("Test slave done");
	endtask

	// Fill with the link refused, then drain through 17 frames
	task automatic t_fifo();
		int n0;
		apb(1'b1, OFS_CTRL, 32'h0000_01CB);
		for (int i = 0; i < FIFO_DEPTH; i++)
			apb(1'b1, OFS_TXDATA, 32'h0000_0010 + i);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("fifo_full", 2'b01, {rd_v[3], rd_v[2]});
		n0 = nfr;
		peer_tx = 8'h42;
		apb(1'b1, OFS_CTRL, 32'h0000_01CF);
		apb(1'b1, OFS_TXDATA, 32'h0000_00EE);
		wait (nfr == n0 + FIFO_DEPTH + 1);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("fifo_empty", 2'b10, {rd_v[3], rd_v[2]});
		`CHK("last_word", 8'hEE, peer_rx);
		$display("Test fifo done");
	endtask

	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, srg_ext_clock, ec} = '0;
		{cyc, wd, nr, nf, nfr, bad_chg, err_count, compares} = '0;
		{p_ck, p_oe, p_so, bit7, oe_seen} = '0;
		p_fs = 1'b1;
		clk_en = 1'b1;
		peer_tx = 8'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_master(8'h01, 1'b1, 2, 8'hA5, 8'h3C);
		t_master(8'h02, 1'b1, 2, 8'h5A, 8'hC3);
		t_master(8'h05, 1'b1, 2, 8'h81, 8'h7E);
		t_master(8'h02, 1'b0, 8, 8'h96, 8'h69);
		t_fifo();
		t_slave(8'hB4, 8'h2D);
		complete_run();
	end
endmodule // serial_port_spi_clock_stop_bench

// >>> verif/spi_peer_model.sv
`timescale 1ns/1ps
module spi_peer_model
(
	input  wire logic       pclk,
	input  wire logic       clk_pin,
	input  wire logic       en_n_pin,
	input  wire logic       mosi,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic            miso_oe,
	output logic            drv_clk,
	output logic            drv_en_n,
	output logic [7:0]      rx_byte
);
	logic [7:0] sh;

	// Idle: clock parked low, enable inactive
	initial
	begin
		sh = 8'h00;
		rx_byte = 8'h00;
		drv_clk = 1'b0;
		drv_en_n = 1'b1;
	end

	// Deselected peer lets its line float to the pull-up
	assign miso_oe = ~en_n_pin;
	assign miso    = sh[7];

	// Load on select, shift on falling clock
	always @(negedge en_n_pin)
		sh = tx_byte;
	always @(negedge clk_pin)
		if (!en_n_pin)
			sh = {sh[6:0], 1'b0};

	// Sample on rising clock
	always @(posedge clk_pin)
		if (!en_n_pin)
			rx_byte = {rx_byte[6:0], mosi};

	// Master role: levels of 4 pclk keep the slave's synchronisers fed
	task automatic run_frame(input logic sel);
		@(posedge pclk);
		drv_en_n <= ~sel;
		repeat (6) @(posedge pclk);
		repeat (8)
		begin
			drv_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			drv_clk <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		repeat (4) @(posedge pclk);
		drv_en_n <= 1'b1;
		@(posedge pclk);
	endtask
endmodule // spi_peer_model
